// [src/spc_pkg.sv]
// package: offsets, field positions, reset values and types for the protect/config bank
package spc_pkg;
  localparam logic [15:0] SPC_ADDR_PROTECT = 16'h4000;
  localparam logic [15:0] SPC_ADDR_RAMSZ = 16'h4002;
  localparam logic [15:0] SPC_ADDR_FLASH = 16'h41B0;
  localparam logic [15:0] SPC_ADDR_EECTL0 = 16'h41C0;
  localparam logic [15:0] SPC_ADDR_EEFLAG = 16'h41C8;
  localparam logic [15:0] SPC_KEY_VALUE = 16'h0096;
  localparam logic [15:0] SPC_PROTECT_RST = 16'h0000;
  localparam logic [2:0] SPC_RAMSZ_RST = 3'h2;
  localparam logic [1:0] SPC_FLASH_RST = 2'h1;
  localparam int SPC_RAMSZ_LSB = 0;
  localparam int SPC_FLASH_LSB = 0;
  localparam int SPC_EE_MODE_BIT = 0;
  localparam int SPC_EE_SUPPLY_BIT = 1;
  localparam int SPC_EE_RESET_BIT = 8;
  localparam int SPC_EE_DONE_BIT = 0;
  localparam logic [2:0] SPC_RAM_512 = 3'h0;
  localparam logic [2:0] SPC_RAM_1K = 3'h1;
  localparam logic [2:0] SPC_RAM_2K = 3'h2;
  localparam logic [11:0] SPC_LIMIT_512 = 12'h200;
  localparam logic [11:0] SPC_LIMIT_1K = 12'h400;
  localparam logic [11:0] SPC_LIMIT_2K = 12'h800;
  typedef struct packed {
    logic reset_release;
    logic supply_on;
    logic reprogram_mode;
  } spc_eectl_t;
endpackage

// [src/spc_rd_reg.sv]
// read data holding register for the register port
`timescale 1ns/100ps
`default_nettype none
module spc_rd_reg #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // zero between reads keeps stale data off the bus
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end else begin
      q <= '0;
    end
  end
endmodule
`default_nettype wire

// [src/spc_regs.sv]
// system protect and configuration register bank
// Summary of operation
// R1 - protection lifts only while the key field holds exactly 0x0096
// R2 - unlocked state holds across writes until a non-key value is stored
// R3 - protected bits ignore writes while protection is on
// R4 - software should relock after finishing protected changes
// R5 - ram size select 0/1/2 gives 512B/1KB/2KB, resets to 2
// R6 - ram accesses beyond the selected size act as reserved accesses
// R7 - flash read cycles field gives 1 to 4 cycles, resets to 1
// R8 - software keeps system clock within the limit of the chosen cycles
// R9 - software sets flash cycles before changing the system clock
// R10 - eeprom reset bit 8: 1 releases, 0 holds reset; resets to 1
// R11 - eeprom reset bit low disables every eeprom control function
// R12 - software pulses eeprom reset if no completion flag appears
// R13 - supply bit turns booster on only while reprogram mode is 1
// R14 - bit 0 enters reprogram mode; reads meanwhile return indefinite data
// R15 - completion flag sets when a reprogram or read finishes
// R16 - reserved bits read zero and ignore writes
// R17 - key register reads back the last value written
`timescale 1ns/100ps
`default_nettype none
module spc_regs
  import spc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic ee_op_done,
  input wire logic ee_read_req,
  input wire logic [11:0] ram_access_addr,
  output logic ram_out_of_range,
  output logic [2:0] ram_size_select,
  output logic [1:0] flash_read_cycles,
  output logic eeprom_reset_release,
  output logic eeprom_program_supply_on,
  output logic eeprom_reprogram_mode,
  output logic eeprom_read_enable,
  output logic eeprom_read_indefinite,
  output logic protect_unlocked
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [15:0] protect_key_field;
  spc_eectl_t ee_ctl;
  logic eeprom_done_flag;
  wire sel_key = (reg_addr == SPC_ADDR_PROTECT);
  wire sel_ram = (reg_addr == SPC_ADDR_RAMSZ);
  wire sel_flash = (reg_addr == SPC_ADDR_FLASH);
  wire sel_ee = (reg_addr == SPC_ADDR_EECTL0);
  wire sel_flag = (reg_addr == SPC_ADDR_EEFLAG);
  wire unlocked = (protect_key_field == SPC_KEY_VALUE); // R1
  wire wp_ok = reg_write && unlocked; // R3
  wire ee_active = ee_ctl.reset_release; // R11

  function automatic logic [11:0] spc_limit(input logic [2:0] code);
    unique case (code)
      SPC_RAM_512: spc_limit = SPC_LIMIT_512;
      SPC_RAM_1K: spc_limit = SPC_LIMIT_1K;
      default: spc_limit = SPC_LIMIT_2K;
    endcase
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      protect_key_field <= SPC_PROTECT_RST;
    end else if (reg_write && sel_key) begin
      protect_key_field <= reg_wdata[15:0]; // R2 R17
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_size_select <= SPC_RAMSZ_RST; // R5
      flash_read_cycles <= SPC_FLASH_RST; // R7
      ee_ctl <= '{reset_release: 1'b1, supply_on: 1'b0, reprogram_mode: 1'b0}; // R10
    end else if (wp_ok) begin
      // R3
      if (sel_ram) begin
        ram_size_select <= reg_wdata[SPC_RAMSZ_LSB +: 3]; // R5
      end
      if (sel_flash) begin
        flash_read_cycles <= reg_wdata[SPC_FLASH_LSB +: 2]; // R7
      end
      if (sel_ee) begin
        ee_ctl.reset_release <= reg_wdata[SPC_EE_RESET_BIT]; // R10
        ee_ctl.supply_on <= reg_wdata[SPC_EE_SUPPLY_BIT];
        ee_ctl.reprogram_mode <= reg_wdata[SPC_EE_MODE_BIT]; // R14
      end
    end
  end

  // set wins over a write-1 clear in the same cycle
  wire done_set = ee_op_done && ee_active; // R15
  wire done_clr = reg_write && sel_flag && reg_wdata[SPC_EE_DONE_BIT];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_done_flag <= 1'b0;
    end else if (!ee_active) begin
      eeprom_done_flag <= 1'b0; // R11
    end else if (done_set) begin
      eeprom_done_flag <= 1'b1; // R15
    end else if (done_clr) begin
      eeprom_done_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire next_supply = ee_active && ee_ctl.supply_on && ee_ctl.reprogram_mode; // R13
  wire next_mode = ee_active && ee_ctl.reprogram_mode; // R11 R14
  wire next_rd_en = ee_active && ee_read_req; // R11
  wire next_rd_x = next_rd_en && ee_ctl.reprogram_mode; // R14
  wire next_oor = (ram_access_addr >= spc_limit(ram_size_select)); // R6
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_reset_release <= 1'b1;
      eeprom_program_supply_on <= 1'b0;
      eeprom_reprogram_mode <= 1'b0;
      eeprom_read_enable <= 1'b0;
      eeprom_read_indefinite <= 1'b0;
      ram_out_of_range <= 1'b0;
      protect_unlocked <= 1'b0;
    end else begin
      eeprom_reset_release <= ee_ctl.reset_release; // R10
      eeprom_program_supply_on <= next_supply;
      eeprom_reprogram_mode <= next_mode;
      eeprom_read_enable <= next_rd_en;
      eeprom_read_indefinite <= next_rd_x;
      ram_out_of_range <= next_oor;
      protect_unlocked <= unlocked;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000; // R16
    if (sel_key) begin
      rd_mux = protect_key_field; // R17
    end else if (sel_ram) begin
      rd_mux = {13'h0000, ram_size_select};
    end else if (sel_flash) begin
      rd_mux = {14'h0000, flash_read_cycles};
    end else if (sel_ee) begin
      rd_mux = {7'h00, ee_ctl.reset_release, 6'h00, ee_ctl.supply_on, ee_ctl.reprogram_mode};
    end else if (sel_flag) begin
      rd_mux = {15'h0000, eeprom_done_flag};
    end
  end

  spc_rd_reg #(.WIDTH(DATA_W)) u_rd (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(reg_read),
    .d(rd_mux),
    .q(reg_rdata)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_locked_ram;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_ram && !unlocked) |=> $stable(ram_size_select);
  endproperty
  a_locked_ram: assert property (p_locked_ram) else $error("ram size changed while locked"); // R3

  property p_locked_ee;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_ee && !unlocked) |=> $stable(ee_ctl);
  endproperty
  a_locked_ee: assert property (p_locked_ee) else $error("eeprom control changed while locked"); // R3

  property p_unlock_key;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_key) |=> ##1 (protect_unlocked == ($past(reg_wdata, 2) == SPC_KEY_VALUE));
  endproperty
  a_unlock_key: assert property (p_unlock_key) else $error("unlock state not tied to key"); // R1

  property p_unlocked_flash;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_flash && unlocked) |=> (flash_read_cycles == $past(reg_wdata[1:0]));
  endproperty
  a_unlocked_flash: assert property (p_unlocked_flash) else $error("flash cycles not written"); // R7

  property p_supply_needs_mode;
    @(posedge sys_clk) disable iff (!reset_n)
      eeprom_program_supply_on |-> eeprom_reprogram_mode;
  endproperty
  a_supply_needs_mode: assert property (p_supply_needs_mode) else $error("supply on outside mode"); // R13

  property p_reset_blocks;
    @(posedge sys_clk) disable iff (!reset_n)
      !ee_ctl.reset_release |=> (!eeprom_read_enable && !eeprom_reprogram_mode);
  endproperty
  a_reset_blocks: assert property (p_reset_blocks) else $error("eeprom active in reset"); // R11

  property p_done_set;
    @(posedge sys_clk) disable iff (!reset_n)
      (ee_op_done && ee_active) |=> eeprom_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set"); // R15

  property p_oor;
    @(posedge sys_clk) disable iff (!reset_n)
      (ram_size_select == 3'h0 && ram_access_addr == 12'h200) |=> ram_out_of_range;
  endproperty
  a_oor: assert property (p_oor) else $error("range limit missed"); // R6

  property p_key_readback;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_key) ##1 (reg_read && sel_key) |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_key_readback: assert property (p_key_readback) else $error("key readback wrong"); // R17

  property p_locked_flash;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_flash && !unlocked) |=> $stable(flash_read_cycles);
  endproperty
  a_locked_flash: assert property (p_locked_flash) else $error("flash cycles changed while locked"); // R3

  property p_unlocked_ram;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_ram && unlocked) |=> (ram_size_select == $past(reg_wdata[2:0]));
  endproperty
  a_unlocked_ram: assert property (p_unlocked_ram) else $error("ram size not written"); // R5

  property p_unlocked_ee;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_ee && unlocked) |=> (ee_ctl.reset_release == $past(reg_wdata[SPC_EE_RESET_BIT]));
  endproperty
  a_unlocked_ee: assert property (p_unlocked_ee) else $error("eeprom reset bit not written"); // R10

  property p_unlock_holds;
    @(posedge sys_clk) disable iff (!reset_n)
      (unlocked && !(reg_write && sel_key)) |=> unlocked;
  endproperty
  a_unlock_holds: assert property (p_unlock_holds) else $error("unlock lost without key write"); // R2

  property p_relock;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_key && (reg_wdata != SPC_KEY_VALUE)) |=> !unlocked;
  endproperty
  a_relock: assert property (p_relock) else $error("non-key value left bank unlocked"); // R1

  property p_supply_on;
    @(posedge sys_clk) disable iff (!reset_n)
      (ee_active && ee_ctl.supply_on && ee_ctl.reprogram_mode) |=> eeprom_program_supply_on;
  endproperty
  a_supply_on: assert property (p_supply_on) else $error("supply not switched on"); // R13

  property p_supply_off;
    @(posedge sys_clk) disable iff (!reset_n)
      !ee_ctl.reprogram_mode |=> !eeprom_program_supply_on;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("supply on without reprogram mode"); // R13

  property p_mode_on;
    @(posedge sys_clk) disable iff (!reset_n)
      (ee_active && ee_ctl.reprogram_mode) |=> eeprom_reprogram_mode;
  endproperty
  a_mode_on: assert property (p_mode_on) else $error("reprogram mode not entered"); // R14

  property p_read_indefinite;
    @(posedge sys_clk) disable iff (!reset_n)
      (ee_active && ee_read_req && ee_ctl.reprogram_mode) |=> eeprom_read_indefinite;
  endproperty
  a_read_indefinite: assert property (p_read_indefinite) else $error("read in mode not marked"); // R14

  property p_flag_off_in_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      !ee_active |=> !eeprom_done_flag;
  endproperty
  a_flag_off_in_reset: assert property (p_flag_off_in_reset) else $error("done flag set in reset"); // R11

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_write && sel_flag && reg_wdata[SPC_EE_DONE_BIT] && !ee_op_done && ee_active) |=> !eeprom_done_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared"); // R15

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!reset_n)
      !reg_read |=> (reg_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // R16

  property p_reserved_read;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_read && !(sel_key || sel_ram || sel_flash || sel_ee || sel_flag)) |=> (reg_rdata == 16'h0000);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("unmapped read not zero"); // R16

  property p_oor_inside;
    @(posedge sys_clk) disable iff (!reset_n)
      (ram_size_select == SPC_RAM_2K && ram_access_addr == 12'h7FF) |=> !ram_out_of_range;
  endproperty
  a_oor_inside: assert property (p_oor_inside) else $error("last ram byte flagged"); // R6

  property p_ram_read;
    @(posedge sys_clk) disable iff (!reset_n)
      (reg_read && sel_ram) |=> (reg_rdata == {13'h0000, $past(ram_size_select)});
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("ram size readback wrong"); // R5 R16
endmodule
`default_nettype wire

// [test/spc_ee_model.sv]
// behavioural far side: eeprom read request level and completion pulse
`timescale 1ns/100ps
`default_nettype none
module spc_ee_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic op_go,
  input wire logic [1:0] op_lat,
  output logic ee_read_req,
  output logic ee_op_done
);
  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  logic [1:0] cnt;
  // latency chosen per operation so both prompt and slow answers occur
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 2'h0;
      ee_read_req <= 1'b0;
      ee_op_done <= 1'b0;
    end else begin
      ee_op_done <= (cnt == 2'h1);
      if (op_go) begin
        cnt <= op_lat;
        ee_read_req <= 1'b1;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
        ee_read_req <= (cnt != 2'h1);
      end
    end
  end
endmodule
`default_nettype wire

// [test/test_system_protect_config_regs.sv]
// self-checking testbench for the protect/config register bank
`timescale 1ns/100ps
`default_nettype none
module test_system_protect_config_regs
  import spc_pkg::*;
;
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, op_go = 1'b0;
  logic [1:0] op_lat = 2'h3;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
  logic [11:0] ram_access_addr = 12'h000;
  logic [15:0] reg_rdata;
  logic ee_op_done, ee_read_req, ram_out_of_range, eeprom_reset_release, eeprom_program_supply_on;
  logic eeprom_reprogram_mode, eeprom_read_enable, eeprom_read_indefinite, protect_unlocked;
  logic [2:0] ram_size_select;
  logic [1:0] flash_read_cycles;
  int bad_count = 0, n_tests = 0, cyc = 0;
  spc_regs uut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .ee_op_done, .ee_read_req, .ram_access_addr, .ram_out_of_range, .ram_size_select,
    .flash_read_cycles, .eeprom_reset_release, .eeprom_program_supply_on, .eeprom_reprogram_mode,
    .eeprom_read_enable, .eeprom_read_indefinite, .protect_unlocked);
  spc_ee_model far (.sys_clk, .reset_n, .op_go, .op_lat, .ee_read_req, .ee_op_done);
  always #25 sys_clk = ~sys_clk;
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic ee_op(input logic [1:0] lat);
    @(posedge sys_clk);
    op_lat <= lat;
    op_go <= 1'b1;
    @(posedge sys_clk);
    op_go <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({4'h0, ram_out_of_range, ram_size_select, flash_read_cycles, eeprom_reset_release,
      eeprom_program_supply_on, eeprom_reprogram_mode, eeprom_read_enable, eeprom_read_indefinite,
      protect_unlocked}, 16'h0260);
    rd(SPC_ADDR_PROTECT, 16'h0000);
    rd(SPC_ADDR_RAMSZ, 16'h0002);
    rd(SPC_ADDR_FLASH, 16'h0001);
    rd(SPC_ADDR_EECTL0, 16'h0100);
    rd(16'h4004, 16'h0000);
    @(negedge sys_clk);
    chk(reg_rdata, 16'h0000);
  endtask
  task automatic t_locked();
    wr(SPC_ADDR_RAMSZ, 16'h0000);
    wr(SPC_ADDR_FLASH, 16'h0003);
    wr(SPC_ADDR_EECTL0, 16'h0003);
    wr_rd(SPC_ADDR_PROTECT, 16'h0095, 16'h0095);
    rd(SPC_ADDR_RAMSZ, 16'h0002);
    rd(SPC_ADDR_FLASH, 16'h0001);
    rd(SPC_ADDR_EECTL0, 16'h0100);
    chk(16'(protect_unlocked), 16'h0000);
  endtask
  task automatic t_unlocked();
    logic [11:0] lim;
    wr(SPC_ADDR_PROTECT, 16'h0096);
    settle();
    chk(16'(protect_unlocked), 16'h0001);
    // several writes in a row while the key stays stored
    for (int i = 0; i < 4; i++) begin
      wr(SPC_ADDR_FLASH, 16'(i));
      rd(SPC_ADDR_FLASH, 16'(i));
      chk(16'(flash_read_cycles), 16'(i));
    end
    for (int i = 0; i < 3; i++) begin
      lim = 12'h200 << i;
      wr(SPC_ADDR_RAMSZ, 16'hFEF8 | 16'(i));
      rd(SPC_ADDR_RAMSZ, 16'(i));
      @(posedge sys_clk) ram_access_addr <= lim - 12'h001;
      settle();
      chk(16'(ram_out_of_range), 16'h0000);
      @(posedge sys_clk) ram_access_addr <= lim;
      settle();
      chk(16'(ram_out_of_range), 16'h0001);
    end
    // reserved size codes fall back to the full 2KB limit
    wr(SPC_ADDR_RAMSZ, 16'h0007);
    @(posedge sys_clk) ram_access_addr <= 12'h7FF;
    settle();
    chk(16'(ram_out_of_range), 16'h0000);
    @(posedge sys_clk) ram_access_addr <= 12'h000;
  endtask
  task automatic t_eeprom();
    wr(SPC_ADDR_EECTL0, 16'h0102);
    settle();
    chk(16'(eeprom_program_supply_on), 16'h0000);
    wr(SPC_ADDR_EECTL0, 16'h0103);
    settle();
    chk(16'({eeprom_program_supply_on, eeprom_reprogram_mode}), 16'h0003);
    ee_op(2'h3);
    @(negedge sys_clk);
    chk(16'({eeprom_read_enable, eeprom_read_indefinite}), 16'h0003);
    for (int k = 0; k < 10 && !ee_op_done; k++) @(negedge sys_clk);
    rd(SPC_ADDR_EEFLAG, 16'h0001);
    wr(SPC_ADDR_EEFLAG, 16'h0001);
    rd(SPC_ADDR_EEFLAG, 16'h0000);
    wr(SPC_ADDR_EECTL0, 16'h0000);
    settle();
    ee_op(2'h1);
    @(negedge sys_clk);
    chk(16'({eeprom_reset_release, eeprom_reprogram_mode, eeprom_read_enable}), 16'h0000);
    rd(SPC_ADDR_EEFLAG, 16'h0000);
    wr(SPC_ADDR_EECTL0, 16'h0100);
    settle();
    chk(16'(eeprom_reset_release), 16'h0001);
    wr(SPC_ADDR_PROTECT, 16'h0000);
    wr(SPC_ADDR_FLASH, 16'h0000);
    rd(SPC_ADDR_FLASH, 16'h0003);
  endtask
  task automatic t_mid_reset();
    wr(SPC_ADDR_PROTECT, 16'h0096);
    wr(SPC_ADDR_RAMSZ, 16'h0000);
    @(negedge sys_clk);
    chk(16'(ram_size_select), 16'h0000);
    @(posedge sys_clk) reset_n <= 1'b0;
    @(negedge sys_clk);
    chk({13'h0000, ram_size_select}, 16'h0002);
    chk(16'(flash_read_cycles), 16'h0001);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    rd(SPC_ADDR_PROTECT, 16'h0000);
    chk(16'(protect_unlocked), 16'h0000);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_locked();
    t_unlocked();
    t_eeprom();
    t_mid_reset();
    finish_test();
  end
endmodule
`default_nettype wire
